/* File: bench/auto_uplink_power_loop_remote_model.sv */
`timescale 1ns/1ps
`default_nettype none
module auto_uplink_power_loop_remote_model #(
  parameter int PERIOD = 4
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       enable,
  input  wire logic       lock_en,
  input  wire logic [7:0] base,
  input  wire logic [6:0] offset,
  output logic            valid,
  output logic [7:0]      eno,
  output logic            lock
);
  int cnt;
  // far demod quality follows our uplink offset, so the loop really closes
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt   <= 0;
      valid <= 1'b0;
      eno   <= 8'h00;
    end else begin
      cnt   <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      valid <= 1'b0;
      eno   <= ~eno; // value not held between reports
      if (enable && lock_en && cnt == 0) begin
        valid <= 1'b1;
        eno   <= base + 8'(offset);
      end
    end
  end
  assign lock = lock_en;
endmodule
`default_nettype wire

/* File: bench/tb_uplink_power_control_loop.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_uplink_power_control_loop;
  localparam int CORR = 20;
  logic        MCLK, SRST, AWVALID, WVALID, BREADY, ARVALID, RREADY;
  logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, TX_ALARM;
  logic        FRAMING_ACTIVE, PACKET_MODE, REMOTE_VALID, REMOTE_LOCK;
  logic        LOCAL_LOCK, rlock;
  logic [7:0]  AWADDR, ARADDR, base, REMOTE_ENO;
  logic [31:0] WDATA, RDATA;
  logic [3:0]  WSTRB;
  logic [1:0]  BRESP, RRESP, bresp_q;
  logic [6:0]  TX_OFFSET;
  int          n_errors, compares, k;
  int          cycles = 0;

  auto_uplink_power_loop_loop #(.CORR_CYCLES(CORR)) i_dut (
    .MCLK(MCLK), .SRST(SRST), .AWADDR(AWADDR), .AWVALID(AWVALID),
    .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID),
    .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
    .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA),
    .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
    .FRAMING_ACTIVE(FRAMING_ACTIVE), .PACKET_MODE(PACKET_MODE),
    .REMOTE_VALID(REMOTE_VALID), .REMOTE_ENO(REMOTE_ENO),
    .REMOTE_LOCK(REMOTE_LOCK), .LOCAL_LOCK(LOCAL_LOCK),
    .TX_OFFSET(TX_OFFSET), .TX_ALARM(TX_ALARM));

  auto_uplink_power_loop_remote_model i_remote (
    .clk(MCLK), .rst(SRST), .enable(1'b1), .lock_en(rlock), .base(base),
    .offset(TX_OFFSET), .valid(REMOTE_VALID), .eno(REMOTE_ENO),
    .lock(REMOTE_LOCK));

  // free-running clock, 20 ns period
  initial begin
    MCLK = 1'b0;
    forever #10 MCLK = ~MCLK;
  end

  // hang guard, well above the longest sequence
  always @(posedge MCLK) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      end_of_test;
    end
  end

  task automatic end_of_test;
    if (n_errors == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge MCLK);
  endtask

  // address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge MCLK);
      if (!ta && AWREADY) begin
        ta = 1'b1;
        AWVALID <= 1'b0;
      end
      if (!tw && WREADY) begin
        tw = 1'b1;
        WVALID <= 1'b0;
      end
    end
    do @(posedge MCLK); while (!BVALID);
    bresp_q = BRESP;
    BREADY <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
                        input logic [1:0] er);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    do @(posedge MCLK); while (!ARREADY);
    ARVALID <= 1'b0;
    do @(posedge MCLK); while (!RVALID);
    RREADY <= 1'b0;
    `CHK(RDATA, e)
    `CHK(RRESP, er)
  endtask

  // offset settles to e within n cycles
  task automatic expect_off(input logic [6:0] e, input int n);
    for (int i = 0; i < n && TX_OFFSET !== e; i++) @(posedge MCLK);
    `CHK(TX_OFFSET, e)
  endtask

  // main sequence
  initial begin
    {SRST, AWVALID, WVALID, BREADY, ARVALID, RREADY} = 6'h20;
    AWADDR = 8'h00;
    ARADDR = 8'h00;
    WDATA = 32'h0;
    WSTRB = 4'hF;
    base = 8'h00;
    {FRAMING_ACTIVE, PACKET_MODE, LOCAL_LOCK, rlock} = 4'h3;
    n_errors = 0;
    compares = 0;
    repeat (12) @(posedge MCLK);
    SRST <= 1'b0;
    @(posedge MCLK);
    rd_chk(auto_uplink_power_loop_pkg::ADDR_TARGET, 32'h1E, 2'h0);
    rd_chk(auto_uplink_power_loop_pkg::ADDR_RANGE, 32'h1, 2'h0);
    rd_chk(8'h18, 32'h0, 2'h2);
    wr(auto_uplink_power_loop_pkg::ADDR_STATUS, 32'h1);
    `CHK(bresp_q, 2'h2)
    wr(auto_uplink_power_loop_pkg::ADDR_TARGET, 32'h96);
    `CHK(bresp_q, 2'h0)
    rd_chk(auto_uplink_power_loop_pkg::ADDR_TARGET, 32'h1E, 2'h0);
    wr(auto_uplink_power_loop_pkg::ADDR_TARGET, 32'h32);
    wr(auto_uplink_power_loop_pkg::ADDR_CTRL, 32'h1);
    cyc(4 * CORR);
    `CHK(TX_OFFSET, 7'h00)
    FRAMING_ACTIVE <= 1'b1;
    expect_off(7'h0A, 6 * CORR);
    `CHK(TX_ALARM, 1'b0)
    wr(auto_uplink_power_loop_pkg::ADDR_CTRL, 32'h3);
    cyc(2);
    `CHK(TX_ALARM, 1'b1)
    rlock <= 1'b0;
    expect_off(7'h00, 3);
    wr(auto_uplink_power_loop_pkg::ADDR_RANGE, 32'h9);
    wr(auto_uplink_power_loop_pkg::ADDR_CTRL, 32'h7);
    expect_off(7'h5A, 3);
    LOCAL_LOCK <= 1'b0;
    expect_off(7'h00, 3);
    wr(auto_uplink_power_loop_pkg::ADDR_CTRL, 32'h0);
    LOCAL_LOCK <= 1'b1;
    rlock <= 1'b1;
    rd_chk(auto_uplink_power_loop_pkg::ADDR_OFFSET, 32'h0, 2'h0);
    // closed loop, error of 2.0 dB below target
    base <= 8'h1E;
    wr(auto_uplink_power_loop_pkg::ADDR_CTRL, 32'h1);
    for (k = 0; k < 3 * CORR && TX_OFFSET === 7'h00; k++) @(posedge MCLK);
    `CHK(TX_OFFSET, 7'h10)
    cyc(CORR - 3);
    `CHK(TX_OFFSET, 7'h10)
    expect_off(7'h14, 8 * CORR);
    cyc(2 * CORR);
    `CHK(TX_OFFSET, 7'h14)
    base <= 8'h50;
    expect_off(7'h00, 30 * CORR);
    cyc(2 * CORR);
    `CHK(TX_OFFSET, 7'h00)
    // readout with the loop off, then the loop in packet mode without framing
    wr(auto_uplink_power_loop_pkg::ADDR_CTRL, 32'h0);
    base <= 8'h33;
    cyc(8);
    rd_chk(auto_uplink_power_loop_pkg::ADDR_REMOTE, 32'h32, 2'h0);
    base <= 8'hB4;
    cyc(8);
    rd_chk(auto_uplink_power_loop_pkg::ADDR_REMOTE, 32'hA0, 2'h0);
    PACKET_MODE <= 1'b1;
    FRAMING_ACTIVE <= 1'b0;
    base <= 8'h33;
    cyc(8);
    rd_chk(auto_uplink_power_loop_pkg::ADDR_REMOTE, 32'h33, 2'h0);
    base <= 8'h00;
    wr(auto_uplink_power_loop_pkg::ADDR_CTRL, 32'h1);
    expect_off(7'h32, 10 * CORR);
    end_of_test;
  end
endmodule
`default_nettype wire

/* File: rtl/auto_uplink_power_loop_loop.sv */
`timescale 1ns/1ps
`default_nettype none
module auto_uplink_power_loop_loop #(
  parameter int CORR_CYCLES = 32'(auto_uplink_power_loop_pkg::CORR_CYCLES)
) (
  input  wire logic        MCLK,
  input  wire logic        SRST,
  input  wire logic [7:0]  AWADDR,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  input  wire logic [7:0]  ARADDR,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input  wire logic        RREADY,
  input  wire logic        FRAMING_ACTIVE,
  input  wire logic        PACKET_MODE,
  input  wire logic        REMOTE_VALID,
  input  wire logic [7:0]  REMOTE_ENO,
  input  wire logic        REMOTE_LOCK,
  input  wire logic        LOCAL_LOCK,
  output logic [6:0]       TX_OFFSET,
  output logic             TX_ALARM
);
  // remote link side status comes from other logic on MCLK, no sync
  logic [2:0]  ctrl_reg;
  logic [7:0]  target_reg;
  logic [3:0]  range_reg;
  logic [6:0]  offset_reg;
  logic [7:0]  remote_reg;
  logic        rvalid_seen_reg;
  logic [31:0] tick_reg;
  logic        fine_reg;
  logic        aw_got_reg, w_got_reg;
  logic [7:0]  awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        loop_on, tick, wr_fire;
  logic [6:0]  range_units, offset_next;
  logic [8:0]  err;
  logic [31:0] rd_word;
  logic        rd_ok;

  // loop allowed when framing up, or in packet mode without framing
  assign loop_on = ctrl_reg[auto_uplink_power_loop_pkg::CTRL_EN_BIT]
                   && (FRAMING_ACTIVE || PACKET_MODE);
  assign range_units = 7'(range_reg) * 7'd10;

  // write channel: address and data taken in either order
  assign AWREADY = !aw_got_reg && !BVALID;
  assign WREADY  = !w_got_reg && !BVALID;
  assign wr_fire = aw_got_reg && w_got_reg && !BVALID;
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      aw_got_reg <= 1'b0;
      w_got_reg  <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg  <= 32'h0000_0000;
      wstrb_reg  <= 4'h0;
      BVALID     <= 1'b0;
      BRESP      <= auto_uplink_power_loop_pkg::RESP_OKAY;
    end else begin
      if (AWVALID && AWREADY) begin
        aw_got_reg <= 1'b1;
        awaddr_reg <= AWADDR;
      end
      if (WVALID && WREADY) begin
        w_got_reg <= 1'b1;
        wdata_reg <= WDATA;
        wstrb_reg <= WSTRB;
      end
      if (wr_fire) begin
        aw_got_reg <= 1'b0;
        w_got_reg  <= 1'b0;
        BVALID     <= 1'b1;
        BRESP      <= (awaddr_reg == auto_uplink_power_loop_pkg::ADDR_CTRL
                       || awaddr_reg == auto_uplink_power_loop_pkg::ADDR_TARGET
                       || awaddr_reg == auto_uplink_power_loop_pkg::ADDR_RANGE)
                      ? auto_uplink_power_loop_pkg::RESP_OKAY : auto_uplink_power_loop_pkg::RESP_SLVERR;
      end else if (BVALID && BREADY) begin
        BVALID <= 1'b0;
      end
    end
  end

  // config registers; out-of-range values are ignored, not clipped
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      ctrl_reg   <= auto_uplink_power_loop_pkg::CTRL_RESET;
      target_reg <= auto_uplink_power_loop_pkg::TARGET_RESET;
      range_reg  <= auto_uplink_power_loop_pkg::RANGE_RESET;
    end else if (wr_fire && wstrb_reg[0]) begin
      unique case (awaddr_reg)
        auto_uplink_power_loop_pkg::ADDR_CTRL:   ctrl_reg <= wdata_reg[2:0];
        auto_uplink_power_loop_pkg::ADDR_TARGET:
          if (wdata_reg[7:0] <= auto_uplink_power_loop_pkg::TARGET_MAX)
            target_reg <= wdata_reg[7:0];
        auto_uplink_power_loop_pkg::ADDR_RANGE:
          if (wdata_reg[3:0] <= auto_uplink_power_loop_pkg::RANGE_MAX
              && wdata_reg[7:4] == 4'h0)
            range_reg <= wdata_reg[3:0];
        default: ;
      endcase
    end
  end

  // remote readout latched when a value arrives with framing or packet mode, loop on or off
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      remote_reg      <= 8'h00;
      rvalid_seen_reg <= 1'b0;
    end else if (REMOTE_VALID && (FRAMING_ACTIVE || PACKET_MODE)) begin
      remote_reg      <= REMOTE_ENO;
      rvalid_seen_reg <= 1'b1;
    end
  end

  // correction pacing; counter freerun keeps interval even after off
  assign tick = (tick_reg == 32'(CORR_CYCLES - 1));
  always_ff @(posedge MCLK) begin
    if (SRST || tick)
      tick_reg <= 32'h0000_0000;
    else
      tick_reg <= tick_reg + 32'h0000_0001;
  end

  // error in 0.1 dB units, positive means remote too weak
  assign err = {1'b0, target_reg} - {1'b0, remote_reg};

  // next offset: coarse 80 percent, fine 0.1 dB within band
  always_comb begin
    logic [8:0] mag;
    logic [8:0] step;
    mag  = err[8] ? (9'd0 - err) : err;
    step = 9'd1;
    offset_next = offset_reg;
    // widened product: 9 bits would wrap for errors above 12.7 dB
    if (!fine_reg && mag >= 9'(auto_uplink_power_loop_pkg::FINE_BAND))
      step = 9'((11'(mag) * 11'd4 + 11'd2) / 11'd5);
    else
      step = (mag == 9'd0) ? 9'd0 : 9'd1;
    if (!err[8]) begin
      // raise, saturate at range
      if (9'(offset_reg) + step >= 9'(range_units))
        offset_next = range_units;
      else
        offset_next = 7'(9'(offset_reg) + step);
    end else begin
      // lower, saturate at nominal
      if (step >= 9'(offset_reg))
        offset_next = 7'h00;
      else
        offset_next = 7'(9'(offset_reg) - step);
    end
  end

  // offset state and fallbacks
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      offset_reg <= 7'h00;
      fine_reg   <= 1'b0;
    end else if (!loop_on || !LOCAL_LOCK) begin
      offset_reg <= 7'h00;
      fine_reg   <= 1'b0;
    end else if (!REMOTE_LOCK) begin
      offset_reg <= ctrl_reg[auto_uplink_power_loop_pkg::CTRL_UNLOCK_BIT]
                    ? range_units : 7'h00;
      fine_reg   <= 1'b0;
    end else if (offset_reg > range_units) begin
      offset_reg <= range_units;
    end else if (tick && rvalid_seen_reg) begin
      offset_reg <= offset_next;
      // once inside the band, stay fine to avoid hunting
      if ((err[8] ? (9'd0 - err) : err) < 9'(auto_uplink_power_loop_pkg::FINE_BAND))
        fine_reg <= 1'b1;
    end
  end

  assign TX_OFFSET = offset_reg;

  // alarm only when chosen and loop sits at its limit
  always_ff @(posedge MCLK) begin
    if (SRST)
      TX_ALARM <= 1'b0;
    else
      TX_ALARM <= ctrl_reg[auto_uplink_power_loop_pkg::CTRL_ALARM_BIT] && loop_on
                  && offset_reg == range_units && REMOTE_LOCK
                  && err != 9'd0 && !err[8];
  end

  // readback; remote shown at 0.2 dB framed, 0.1 dB in packet mode
  always_comb begin
    logic [7:0] shown;
    shown = (remote_reg >= auto_uplink_power_loop_pkg::ENO_CLAMP)
            ? auto_uplink_power_loop_pkg::ENO_CLAMP : remote_reg;
    if (!PACKET_MODE)
      shown = {shown[7:1], 1'b0};
    rd_ok   = 1'b1;
    rd_word = 32'h0000_0000;
    unique case (ARADDR)
      auto_uplink_power_loop_pkg::ADDR_CTRL:   rd_word = {29'h0, ctrl_reg};
      auto_uplink_power_loop_pkg::ADDR_TARGET: rd_word = {24'h0, target_reg};
      auto_uplink_power_loop_pkg::ADDR_RANGE:  rd_word = {28'h0, range_reg};
      auto_uplink_power_loop_pkg::ADDR_STATUS: rd_word = {28'h0, TX_ALARM, fine_reg,
                                        rvalid_seen_reg, loop_on};
      auto_uplink_power_loop_pkg::ADDR_REMOTE: rd_word = {24'h0, shown};
      auto_uplink_power_loop_pkg::ADDR_OFFSET: rd_word = {25'h0, offset_reg};
      default:               rd_ok   = 1'b0;
    endcase
  end

  // read channel: one outstanding read
  assign ARREADY = !RVALID;
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      RVALID <= 1'b0;
      RDATA  <= 32'h0000_0000;
      RRESP  <= auto_uplink_power_loop_pkg::RESP_OKAY;
    end else if (ARVALID && ARREADY) begin
      RVALID <= 1'b1;
      RDATA  <= rd_word;
      RRESP  <= rd_ok ? auto_uplink_power_loop_pkg::RESP_OKAY : auto_uplink_power_loop_pkg::RESP_SLVERR;
    end else if (RVALID && RREADY) begin
      RVALID <= 1'b0;
    end
  end

  property p_local_unlock;
    @(posedge MCLK) disable iff (SRST)
      !LOCAL_LOCK |=> offset_reg == 7'h00;
  endproperty
  a_local_unlock: assert property (p_local_unlock)
    else $error("offset not nominal after local unlock");
  property p_range;
    @(posedge MCLK) disable iff (SRST)
      $stable(range_reg) |-> offset_reg <= range_units;
  endproperty
  a_range: assert property (p_range)
    else $error("offset above range");
  property p_off_zero;
    @(posedge MCLK) disable iff (SRST)
      !loop_on |=> offset_reg == 7'h00;
  endproperty
  a_off_zero: assert property (p_off_zero)
    else $error("offset nonzero with loop off");
  property p_pace;
    @(posedge MCLK) disable iff (SRST)
      (loop_on && LOCAL_LOCK && REMOTE_LOCK && !tick
       && offset_reg <= range_units && $stable(range_reg))
      |=> $stable(offset_reg);
  endproperty
  a_pace: assert property (p_pace)
    else $error("offset changed between ticks");
  property p_target_max;
    @(posedge MCLK) disable iff (SRST) target_reg <= auto_uplink_power_loop_pkg::TARGET_MAX;
  endproperty
  a_target_max: assert property (p_target_max)
    else $error("target out of range");
  property p_remote_unlock;
    @(posedge MCLK) disable iff (SRST)
      (loop_on && LOCAL_LOCK && !REMOTE_LOCK
       && !ctrl_reg[auto_uplink_power_loop_pkg::CTRL_UNLOCK_BIT]) |=> offset_reg == 7'h00;
  endproperty
  a_remote_unlock: assert property (p_remote_unlock)
    else $error("offset not nominal after remote unlock");
  property p_alarm;
    @(posedge MCLK) disable iff (SRST)
      !ctrl_reg[auto_uplink_power_loop_pkg::CTRL_ALARM_BIT] |=> !TX_ALARM;
  endproperty
  a_alarm: assert property (p_alarm)
    else $error("alarm raised while disabled");
  property p_raise;
    @(posedge MCLK) disable iff (SRST)
      (tick && loop_on && LOCAL_LOCK && REMOTE_LOCK && rvalid_seen_reg
       && !err[8] && err != 9'd0 && offset_reg < range_units)
      |=> offset_reg > $past(offset_reg);
  endproperty
  a_raise: assert property (p_raise)
    else $error("offset not raised when remote below target");
  c_raise:  cover property (@(posedge MCLK) tick && !err[8] && loop_on);
  c_limit:  cover property (@(posedge MCLK) TX_ALARM);
  c_fine:   cover property (@(posedge MCLK) fine_reg);
  c_unlock: cover property (@(posedge MCLK) loop_on && !REMOTE_LOCK);
endmodule
`default_nettype wire

/* File: rtl/auto_uplink_power_loop_pkg.sv */
// Behaviour
// - loop runs only with supported framing active
// - below target raises transmit power offset
// - target 0.0 to 14.9 dB, reset 3.0
// - above target lowers power, never below nominal
// - max range 0 to 9 dB, default 1
// - at limit: no action or transmit alarm
// - remote unlock: go nominal or full range
// - local unlock returns output to nominal
// - at most one correction every 4 seconds
// - first correction is 80 percent of step
// - fine 0.1 dB steps once error below 0.5
// - remote readout 0.2 dB steps, clamp 16.0
// - readout valid with framing, loop disabled too
// - power increase reads 0.0 when loop disabled
// - packet mode needs no framing, no upper target (code still ignores targets above 14.9 dB in packet mode)
// - packet mode readout at 0.1 dB resolution
package auto_uplink_power_loop_pkg;
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_TARGET  = 8'h04;
  localparam logic [7:0] ADDR_RANGE   = 8'h08;
  localparam logic [7:0] ADDR_STATUS  = 8'h0C;
  localparam logic [7:0] ADDR_REMOTE  = 8'h10;
  localparam logic [7:0] ADDR_OFFSET  = 8'h14;
  localparam int CTRL_EN_BIT     = 0;
  localparam int CTRL_ALARM_BIT  = 1;
  localparam int CTRL_UNLOCK_BIT = 2;
  localparam logic [2:0] CTRL_RESET     = 3'h0;
  localparam logic [7:0] TARGET_RESET   = 8'h1E;
  localparam logic [7:0] TARGET_MAX     = 8'h95;
  localparam logic [3:0] RANGE_RESET    = 4'h1;
  localparam logic [3:0] RANGE_MAX      = 4'h9;
  localparam logic [7:0] ENO_CLAMP      = 8'hA0;
  localparam logic [7:0] FINE_BAND      = 8'h05;
  localparam longint CLK_HZ            = 50000000;
  localparam longint CORR_INTERVAL_S   = 4;
  localparam longint CORR_CYCLES       = CLK_HZ * CORR_INTERVAL_S;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: rtl/unused_none.sv */
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire
